// *** adsq_afe_model.sv ***
// Analog front end model: comparator against a level on input 0
// Assumes the controller synchronises cmp_o on its own clock
`timescale 1ns/1ps
module adsq_afe_model (
  // Controller side
  input wire logic [9:0] dac_i,
  input wire logic [1:0] chan_i,
  // Analog level of input 0
  input wire logic [9:0] analog_input_0_i,
  // Comparator result
  output logic cmp_o
);
  // Only input 0 is wired; other channels give a moving pattern
  assign cmp_o = (chan_i == 2'h0) ? (analog_input_0_i >= dac_i) : dac_i[0];
endmodule : adsq_afe_model

// *** adsq_ctrl.sv ***
// Software-triggered sequential converter control, select mode only
// Assumes an external comparator and DAC around the SAR trial code
`timescale 1ns/1ps
`include "adsq_defs.svh"
module adsq_ctrl #(
  parameter int RES_BITS = `ADSQ_RES_BITS,
  parameter int SETTLE_CYC = `ADSQ_CONV_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register port
  input wire adsq_pkg::adsq_bus_t bus_i,
  output logic [7:0] rdata_o,
  // Analog front end
  input wire logic cmp_i,
  output logic [RES_BITS-1:0] dac_o,
  output logic [1:0] chan_sel_o,
  // Interrupt
  output logic conversion_end_irq_o
);
  import adsq_pkg::*;
  localparam int CW = $clog2(SETTLE_CYC + 1);
  typedef struct packed {
    logic [7:0] mode0;
    logic [7:0] perclk;
    logic [15:0] result;
    logic eoc_st;
    logic eoc_mask;
    logic [7:0] rdata;
    logic irq;
    logic [CW-1:0] cnt;
    adsq_state_t fsm;
    logic cmp_s1;
    logic cmp_s2;
    logic [RES_BITS-1:0] dac;
    logic [1:0] chan;
  } adsq_st_t;
  adsq_st_t st_r;
  adsq_st_t st_nxt;
  logic sar_start;
  logic [RES_BITS-1:0] sar_trial;
  logic [RES_BITS-1:0] sar_code;
  logic sar_done;
  logic run_ok;
  logic [15:0] res_word;
  logic conv_cmpl;
  // Converter may run only with clock gate, start and enable bits
  assign run_ok = st_r.perclk[`ADSQ_BIT_CLKGATE]
    & st_r.mode0[`ADSQ_BIT_START] & st_r.mode0[`ADSQ_BIT_ENABLE];
  assign sar_start = (st_r.fsm == ADSQ_CONV) && (st_r.cnt == CW'(1));
  // Completion edge: search finished while still allowed to run
  assign conv_cmpl = (st_r.fsm == ADSQ_CONV) && (st_r.cnt == '0) && sar_done
    && run_ok;
  // Ten-bit code left aligned, low six bits zero
  assign res_word = {sar_code, {`ADSQ_RES_SHIFT{1'b0}}};
  adsq_sar #(
    .BITS(RES_BITS)
  ) u_sar (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(sar_start),
    .cmp_i(st_r.cmp_s2),
    .trial_o(sar_trial),
    .code_o(sar_code),
    .done_o(sar_done)
  );
  // Next state: registers, sequencer, interrupt
  always_comb begin
    st_nxt = st_r;
    st_nxt.cmp_s1 = cmp_i;
    st_nxt.cmp_s2 = st_r.cmp_s1;
    st_nxt.dac = sar_trial;
    st_nxt.rdata = 8'h00;
    // Select mode pins channel 0; scan mode left on channel 0 too
    st_nxt.chan = 2'h0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        `ADSQ_ADDR_MODE0: st_nxt.rdata = st_r.mode0;
        `ADSQ_ADDR_RESULT: st_nxt.rdata = st_r.result[15:8];
        `ADSQ_ADDR_PERCLK: st_nxt.rdata = st_r.perclk;
        `ADSQ_ADDR_STATUS: st_nxt.rdata = {7'h00, st_r.eoc_st};
        `ADSQ_ADDR_MASK: st_nxt.rdata = {7'h00, st_r.eoc_mask};
        `ADSQ_ADDR_CHAN: st_nxt.rdata = st_r.result[7:0];
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    if (bus_i.wr) begin
      case (bus_i.addr)
        `ADSQ_ADDR_MODE0: st_nxt.mode0 = bus_i.wdata;
        `ADSQ_ADDR_PERCLK: st_nxt.perclk = bus_i.wdata;
        `ADSQ_ADDR_STATUS: begin
          if (bus_i.wdata[`ADSQ_BIT_EOC]) begin
            st_nxt.eoc_st = 1'b0;
          end
        end
        `ADSQ_ADDR_MASK: st_nxt.eoc_mask = bus_i.wdata[`ADSQ_BIT_EOC];
        default: st_nxt.eoc_st = st_r.eoc_st;
      endcase
    end
    case (st_r.fsm)
      ADSQ_IDLE: begin
        if (run_ok) begin
          st_nxt.fsm = ADSQ_CONV;
          st_nxt.cnt = CW'(SETTLE_CYC);
        end
      end
      ADSQ_CONV: begin
        if (!run_ok) begin
          st_nxt.fsm = ADSQ_IDLE;
        end else if (st_r.cnt > CW'(1)) begin
          st_nxt.cnt = st_r.cnt - CW'(1);
        end else if (st_r.cnt == CW'(1)) begin
          st_nxt.cnt = '0;
        end else if (sar_done) begin
          st_nxt.fsm = ADSQ_DONE;
          st_nxt.result = res_word;
          st_nxt.eoc_st = 1'b1;
        end
      end
      ADSQ_DONE: begin
        // Sequential mode: go again while start stays set
        if (run_ok) begin
          st_nxt.fsm = ADSQ_CONV;
          st_nxt.cnt = CW'(SETTLE_CYC);
        end else begin
          st_nxt.fsm = ADSQ_IDLE;
        end
      end
      default: st_nxt.fsm = ADSQ_IDLE;
    endcase
    // Start bit drops when the clock gate is off
    if (!st_nxt.perclk[`ADSQ_BIT_CLKGATE]) begin
      st_nxt.mode0[`ADSQ_BIT_START] = 1'b0;
    end
    st_nxt.irq = st_nxt.eoc_st & st_nxt.eoc_mask;
  end
  // State register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.mode0 <= `ADSQ_RST_MODE0;
      st_r.perclk <= `ADSQ_RST_PERCLK;
      st_r.eoc_mask <= 1'b0;
      st_r.fsm <= ADSQ_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign rdata_o = st_r.rdata;
  assign dac_o = st_r.dac;
  assign chan_sel_o = st_r.chan;
  assign conversion_end_irq_o = st_r.irq;

  // Result register: changes only at completion, always left aligned
  AST_RES_HOLD: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    (st_r.fsm != ADSQ_CONV) |=> $stable(st_r.result))
    else $error("result changed outside a completion");
  AST_DONE_SETS: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    (st_r.fsm == ADSQ_DONE) |-> st_r.eoc_st && (st_r.result[5:0] == 6'h00))
    else $error("completion without status or alignment");
  // Sequencer: start, restart, stop and clock gate
  AST_NO_CLK: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    !st_r.perclk[`ADSQ_BIT_CLKGATE] |=> (st_r.fsm != ADSQ_CONV))
    else $error("converting with clock gate off");
  AST_START: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    (st_r.fsm == ADSQ_IDLE) && run_ok |=> (st_r.fsm == ADSQ_CONV))
    else $error("start bit did not start conversion");
  AST_RESTART: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    (st_r.fsm == ADSQ_DONE) && run_ok |=> (st_r.fsm == ADSQ_CONV))
    else $error("sequential restart missing");
  AST_STOP: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    (st_r.fsm == ADSQ_CONV) && !run_ok |=> (st_r.fsm == ADSQ_IDLE))
    else $error("conversion kept running after stop");
  AST_GATE_START: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    !st_r.perclk[`ADSQ_BIT_CLKGATE] |-> !st_r.mode0[`ADSQ_BIT_START])
    else $error("start bit set with clock gate off");
  // Interrupt: level follows unmasked status
  AST_IRQ: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    $rose(st_r.eoc_st) && st_r.eoc_mask |-> conversion_end_irq_o)
    else $error("interrupt not raised");
  AST_IRQ_LEVEL: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    conversion_end_irq_o == (st_r.eoc_st && st_r.eoc_mask))
    else $error("interrupt level differs from masked status");
  // Status flag: a completion sets it, a write of one clears it
  AST_SET_WINS: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    conv_cmpl |=> st_r.eoc_st && (st_r.fsm == ADSQ_DONE))
    else $error("completion did not set status");
  AST_CLEAR: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    bus_i.wr && (bus_i.addr == `ADSQ_ADDR_STATUS)
    && bus_i.wdata[`ADSQ_BIT_EOC] && !conv_cmpl |=> !st_r.eoc_st)
    else $error("status bit not cleared by write of one");
  // Channel and data path
  AST_CHAN0: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    (st_r.fsm == ADSQ_CONV) |-> (chan_sel_o == 2'h0))
    else $error("wrong channel");
  AST_RESULT: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    conv_cmpl |=> (st_r.result == $past(res_word)))
    else $error("result not loaded");
endmodule : adsq_ctrl

// *** adsq_defs.svh ***
// Constants for the sequential software-triggered converter control
// Assumes inclusion by the controller, the SAR core and the bench of this block
`ifndef ADSQ_DEFS_SVH
`define ADSQ_DEFS_SVH
// Register addresses
`define ADSQ_ADDR_MODE0 4'h0
`define ADSQ_ADDR_RESULT 4'h1
`define ADSQ_ADDR_PERCLK 4'h2
`define ADSQ_ADDR_STATUS 4'h3
`define ADSQ_ADDR_MASK 4'h4
`define ADSQ_ADDR_CHAN 4'h5
// Mode register 0 fields
`define ADSQ_BIT_START 7
`define ADSQ_BIT_CHMODE 6
`define ADSQ_BIT_ENABLE 0
// Peripheral enable register 0 field
`define ADSQ_BIT_CLKGATE 5
// Status and mask field
`define ADSQ_BIT_EOC 0
// Reset values
`define ADSQ_RST_MODE0 8'h00
`define ADSQ_RST_PERCLK 8'h00
`define ADSQ_RST_MASK 8'h00
// Result layout: value left aligned in 16 bits
`define ADSQ_RES_BITS 10
`define ADSQ_RES_SHIFT 6
// Conversion timing
`define ADSQ_CLK_MHZ 25
`define ADSQ_CONV_NS 2000
`define ADSQ_CONV_CYC ((`ADSQ_CONV_NS * `ADSQ_CLK_MHZ + 999) / 1000)
// Comparator answer lag: DAC register plus two synchroniser flops
`define ADSQ_CMP_LAG 3
`endif

// *** adsq_pkg.sv ***
// Types for the sequential software-triggered converter control
// Assumes the definitions header is compiled alongside
package adsq_pkg;
  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adsq_bus_t;
  // Converter sequencing states, one-hot
  typedef enum logic [2:0] {
    ADSQ_IDLE = 3'b001,
    ADSQ_CONV = 3'b010,
    ADSQ_DONE = 3'b100
  } adsq_state_t;
endpackage : adsq_pkg

// *** adsq_sar.sv ***
// Successive approximation core: one bit decided per step, MSB first
// Assumes the comparator input is synchronised to mclk_i and answers
// a new trial code three cycles after it leaves this module
`timescale 1ns/1ps
`include "adsq_defs.svh"
module adsq_sar #(
  parameter int BITS = 10
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic cmp_i,
  // Trial code and result
  output logic [BITS-1:0] trial_o,
  output logic [BITS-1:0] code_o,
  output logic done_o
);
  // Each decision waits out the comparator lag, else it uses a stale answer
  localparam logic [1:0] LAG = 2'(`ADSQ_CMP_LAG);
  typedef struct packed {
    logic [BITS-1:0] code;
    logic [BITS-1:0] mask;
    logic [1:0] hold;
    logic busy;
    logic done;
  } adsq_sar_st_t;
  adsq_sar_st_t st_r;
  adsq_sar_st_t st_nxt;
  // Next-state for the bit search
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start_i) begin
      st_nxt.code = '0;
      st_nxt.mask = {1'b1, {(BITS-1){1'b0}}};
      st_nxt.hold = LAG;
      st_nxt.busy = 1'b1;
    end else if (st_r.busy) begin
      if (st_r.hold != 2'h0) begin
        st_nxt.hold = st_r.hold - 2'h1;
      end else begin
        if (cmp_i) begin
          st_nxt.code = st_r.code | st_r.mask;
        end
        st_nxt.mask = st_r.mask >> 1;
        st_nxt.hold = LAG;
        if (st_r.mask[0]) begin
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
        end
      end
    end
  end
  // State register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign trial_o = st_r.code | st_r.mask;
  assign code_o = st_r.code;
  assign done_o = st_r.done;
endmodule : adsq_sar

// *** tb.sv ***
// Self-checking bench for the sequential converter control
// Assumes the package, header and design modules are compiled first
`timescale 1ns/1ps
`include "adsq_defs.svh"
module tb;
  import adsq_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  adsq_bus_t bus_r = '0;
  logic [7:0] rdata_o;
  logic cmp_w;
  logic [9:0] dac_o;
  logic [1:0] chan_sel_o;
  logic irq_o;
  logic [9:0] level_r = 10'h000;
  logic [7:0] hi;
  logic [7:0] lo;
  int n_mismatch = 0;
  int checked = 0;
  int seed = 32'hf9ed;
  int lvs[5] = '{0, 1023, 341, 0, 0};
  int exp_res;
  // Design with a short settle count
  adsq_ctrl #(.SETTLE_CYC(2)) DUT (.mclk_i(mclk_i), .rst_i(rst_i),
    .bus_i(bus_r), .rdata_o(rdata_o), .cmp_i(cmp_w), .dac_o(dac_o),
    .chan_sel_o(chan_sel_o), .conversion_end_irq_o(irq_o));
  // Far side: analog input and comparator
  adsq_afe_model afe (.dac_i(dac_o), .chan_i(chan_sel_o), .analog_input_0_i(level_r),
    .cmp_o(cmp_w));
  // 25 MHz clock
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i) bus_r <= '{addr:a, wdata:d, wr:1'b1, rd:1'b0};
    @(posedge mclk_i) bus_r.wr <= 1'b0;
  endtask : wr
  // One-cycle read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_i) bus_r <= '{addr:a, wdata:8'h00, wr:1'b0, rd:1'b1};
    @(posedge mclk_i) bus_r.rd <= 1'b0;
    @(negedge mclk_i) d = rdata_o;
  endtask : rd
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, e}, "register read");
  endtask : rchk
  // Bounded wait for the interrupt, after the clear has landed
  task automatic wait_irq;
    int k;
    repeat (2) @(posedge mclk_i);
    for (k = 0; k < 300 && irq_o !== 1'b1; k++) @(negedge mclk_i);
    if (irq_o !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t interrupt timeout", $time);
      summarize();
    end
  endtask : wait_irq
  // Result register read as high then low byte
  task automatic rd_res;
    rd(`ADSQ_ADDR_RESULT, hi);
    rd(`ADSQ_ADDR_CHAN, lo);
  endtask : rd_res
  // Main sequence
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    rchk(`ADSQ_ADDR_MODE0, `ADSQ_RST_MODE0);
    rchk(`ADSQ_ADDR_PERCLK, `ADSQ_RST_PERCLK);
    rchk(`ADSQ_ADDR_MASK, `ADSQ_RST_MASK);
    rchk(4'hf, 8'h00);
    $display("reset test done");
    // Start with the clock gate off: nothing converts
    wr(`ADSQ_ADDR_MODE0, 8'h81);
    repeat (60) @(posedge mclk_i);
    rchk(`ADSQ_ADDR_STATUS, 8'h00);
    wr(`ADSQ_ADDR_MODE0, 8'h00);
    $display("gate test done");
    // Sequential conversions over boundary, fixed and random levels
    lvs[3] = $random(seed) & 32'h3ff;
    lvs[4] = $random(seed) & 32'h3ff;
    wr(`ADSQ_ADDR_PERCLK, 8'h20);
    wr(`ADSQ_ADDR_MASK, 8'h01);
    wr(`ADSQ_ADDR_MODE0, 8'h81);
    for (int i = 0; i < 5; i++) begin
      level_r <= lvs[i][9:0];
      wr(`ADSQ_ADDR_STATUS, 8'h01);
      wait_irq();
      wr(`ADSQ_ADDR_STATUS, 8'h01);
      wait_irq();
      chk({15'h0000, irq_o}, 16'h0001, "irq");
      rd_res();
      exp_res = lvs[i] << `ADSQ_RES_SHIFT;
      chk({hi, lo}, exp_res[15:0], "result");
      chk({hi, lo} >> 6, lvs[i][15:0], "shifted");
      chk({14'h0000, chan_sel_o}, 16'h0000, "channel");
    end
    $display("sequential test done");
    // Masked: status still set by further conversions, no interrupt
    wr(`ADSQ_ADDR_MASK, 8'h00);
    wr(`ADSQ_ADDR_STATUS, 8'h01);
    repeat (60) @(negedge mclk_i);
    chk({15'h0000, irq_o}, 16'h0000, "masked irq");
    rchk(`ADSQ_ADDR_STATUS, 8'h01);
    $display("mask test done");
    // Stop: result holds, no new completions
    wr(`ADSQ_ADDR_MODE0, 8'h01);
    wr(`ADSQ_ADDR_STATUS, 8'h01);
    level_r <= 10'h2aa;
    repeat (60) @(posedge mclk_i);
    rd_res();
    chk({hi, lo}, exp_res[15:0], "held result");
    rchk(`ADSQ_ADDR_STATUS, 8'h00);
    $display("stop test done");
    summarize();
  end
endmodule : tb
